/* hdl/fag_core.sv */
`timescale 1ns/1ps
module fag_core import fag_pkg::*; (
	input wire logic i_core_clk,
	input wire logic i_reset,
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_ack,
	output logic [31:0] o_wb_dat
);
	typedef struct packed {
		logic [15:0] flags;
		logic [15:0] opa;
		logic [15:0] opb;
		logic [15:0] result;
		logic alu_word;
		logic alu_done;
		logic [3:0][15:0] seg;
		logic [15:0] base_b;
		logic [15:0] base_sp;
		logic [15:0] src_idx;
		logic [15:0] dst_idx;
		logic [15:0] port_addr;
		logic [15:0] ea_ctrl;
		logic [15:0] disp;
		logic [15:0] ea_off;
		logic [1:0] ea_seg;
		logic [15:0] ea_seg_val;
		logic [15:0] io_ctrl;
		logic [15:0] io_addr;
		logic io_rsv;
		logic [7:0] vec;
		logic taken;
		logic fault;
		logic [15:0] saved;
		logic ack;
		logic [31:0] dat;
	} fag_state_type;

	fag_state_type st_reg;
	fag_state_type st_next;
	logic [15:0] alu_res;
	logic alu_c;
	logic alu_p;
	logic alu_a;
	logic alu_z;
	logic alu_s;
	logic alu_o;
	logic [15:0] ag_off;
	logic [1:0] ag_seg;
	logic [15:0] ag_seg_val;

	fag_alu_flags u_alu (
		.i_op(i_wb_dat[ALU_OP_LSB +: 3]),
		.i_word(i_wb_dat[ALU_WORD_BIT]),
		.i_a(st_reg.opa),
		.i_b(st_reg.opb),
		.i_carry(st_reg.flags[FLG_CARRY]),
		.o_result(alu_res),
		.o_carry(alu_c),
		.o_parity(alu_p),
		.o_aux(alu_a),
		.o_zero(alu_z),
		.o_sign(alu_s),
		.o_ovf(alu_o)
	);

	fag_addr_gen u_addr (
		.i_ctrl(st_reg.ea_ctrl),
		.i_disp(st_reg.disp),
		.i_base_b(st_reg.base_b),
		.i_base_sp(st_reg.base_sp),
		.i_src_idx(st_reg.src_idx),
		.i_dst_idx(st_reg.dst_idx),
		.i_seg(st_reg.seg),
		.o_offset(ag_off),
		.o_seg_idx(ag_seg),
		.o_seg_val(ag_seg_val)
	);

	function automatic logic [15:0] fag_merge(input logic [15:0] old, input logic [31:0] wd, input logic [3:0] sel);
		logic [15:0] m;
		m = old;
		if (sel[0]) begin
			m[7:0] = wd[7:0];
		end
		if (sel[1]) begin
			m[15:8] = wd[15:8];
		end
		return m;
	endfunction : fag_merge

	function automatic logic [31:0] fag_read(input fag_state_type s, input logic [7:0] adr);
		logic [31:0] r;
		r = 32'h0000_0000;
		if (adr >= OFF_SEG_BASE && adr < OFF_BASE_B && adr[1:0] == 2'b00) begin
			r = {16'h0000, s.seg[2'(adr[7:2] - OFF_SEG_BASE[7:2])]};
		end
		case (adr)
			OFF_FLAGS: r = {16'h0000, s.flags};
			OFF_OPA: r = {16'h0000, s.opa};
			OFF_OPB: r = {16'h0000, s.opb};
			OFF_RESULT: r = {16'h0000, s.result};
			OFF_BASE_B: r = {16'h0000, s.base_b};
			OFF_BASE_SP: r = {16'h0000, s.base_sp};
			OFF_SRC_IDX: r = {16'h0000, s.src_idx};
			OFF_DST_IDX: r = {16'h0000, s.dst_idx};
			OFF_PORT_ADDR: r = {16'h0000, s.port_addr};
			OFF_EA_CTRL: r = {16'h0000, s.ea_ctrl};
			OFF_DISP: r = {16'h0000, s.disp};
			OFF_EA_PTR: r = {s.ea_seg_val, s.ea_off};
			OFF_IO_CTRL: r = {16'h0000, s.io_ctrl};
			OFF_IO_ADDR: r = {15'h0000, s.io_rsv, s.io_addr};
			OFF_EVT_STATUS: r = {s.saved, 6'h00, s.fault, s.taken, s.vec};
			// Digit checks on the low byte of operand A
			OFF_BCD_STATUS: r = {30'h0000_0000, (s.opa[7:4] <= 4'h9) && (s.opa[3:0] <= 4'h9),
				(s.opa[7:0] <= 8'h09)};
			default: ;
		endcase
		return r;
	endfunction : fag_read

	always_comb begin
		logic req;
		logic [7:0] vec_in;
		logic [15:0] step;
		logic take;
		st_next = st_reg;
		st_next.ack = 1'b0;
		st_next.alu_done = 1'b0;
		st_next.ea_off = ag_off;
		st_next.ea_seg = ag_seg;
		st_next.ea_seg_val = ag_seg_val;
		st_next.io_addr = st_reg.io_ctrl[IO_IMM_BIT] ? {8'h00, st_reg.io_ctrl[IO_PORT_LSB +: 8]}
			: st_reg.port_addr;
		// Flags a reserved port so software can spot a bad decode
		st_next.io_rsv = (st_next.io_addr >= IO_RSV_LO) && (st_next.io_addr <= IO_RSV_HI);
		req = i_wb_cyc && i_wb_stb && !st_reg.ack;
		vec_in = i_wb_dat[EVT_VEC_LSB +: 8];
		step = i_wb_dat[STR_WORD_BIT] ? 16'h0002 : 16'h0001;
		take = 1'b0;
		if (req) begin
			st_next.ack = 1'b1;
			st_next.dat = fag_read(st_reg, i_wb_adr);
		end
		if (req && i_wb_we) begin
			if (i_wb_adr >= OFF_SEG_BASE && i_wb_adr < OFF_BASE_B && i_wb_adr[1:0] == 2'b00) begin
				st_next.seg[2'(i_wb_adr[7:2] - OFF_SEG_BASE[7:2])] =
					fag_merge(st_reg.seg[2'(i_wb_adr[7:2] - OFF_SEG_BASE[7:2])], i_wb_dat, i_wb_sel);
			end
			case (i_wb_adr)
				OFF_FLAGS: st_next.flags = (fag_merge(st_reg.flags, i_wb_dat, i_wb_sel) & FLAGS_WMASK) | FLAGS_RESET;
				OFF_OPA: st_next.opa = fag_merge(st_reg.opa, i_wb_dat, i_wb_sel);
				OFF_OPB: st_next.opb = fag_merge(st_reg.opb, i_wb_dat, i_wb_sel);
				OFF_BASE_B: st_next.base_b = fag_merge(st_reg.base_b, i_wb_dat, i_wb_sel);
				OFF_BASE_SP: st_next.base_sp = fag_merge(st_reg.base_sp, i_wb_dat, i_wb_sel);
				OFF_SRC_IDX: st_next.src_idx = fag_merge(st_reg.src_idx, i_wb_dat, i_wb_sel);
				OFF_DST_IDX: st_next.dst_idx = fag_merge(st_reg.dst_idx, i_wb_dat, i_wb_sel);
				OFF_PORT_ADDR: st_next.port_addr = fag_merge(st_reg.port_addr, i_wb_dat, i_wb_sel);
				OFF_EA_CTRL: st_next.ea_ctrl = fag_merge(st_reg.ea_ctrl, i_wb_dat, i_wb_sel);
				OFF_DISP: st_next.disp = fag_merge(st_reg.disp, i_wb_dat, i_wb_sel);
				OFF_IO_CTRL: st_next.io_ctrl = fag_merge(st_reg.io_ctrl, i_wb_dat, i_wb_sel);
				OFF_ALU_CTRL: begin
					st_next.result = alu_res;
					st_next.alu_word = i_wb_dat[ALU_WORD_BIT];
					st_next.alu_done = 1'b1;
					st_next.flags[FLG_CARRY] = alu_c;
					st_next.flags[FLG_PARITY] = alu_p;
					st_next.flags[FLG_AUX] = alu_a;
					st_next.flags[FLG_ZERO] = alu_z;
					st_next.flags[FLG_SIGN] = alu_s;
					st_next.flags[FLG_OVF] = alu_o;
				end
				OFF_STR_STEP: begin
					if (i_wb_dat[STR_SRC_BIT]) begin
						st_next.src_idx = st_reg.flags[FLG_DIR] ? st_reg.src_idx - step : st_reg.src_idx + step;
					end
					if (i_wb_dat[STR_DST_BIT]) begin
						st_next.dst_idx = st_reg.flags[FLG_DIR] ? st_reg.dst_idx - step : st_reg.dst_idx + step;
					end
				end
				OFF_EVENT: begin
					st_next.fault = 1'b0;
					case (fag_evt_type'(i_wb_dat[EVT_KIND_LSB +: 3]))
						EV_INSTR_DONE: begin
							take = st_reg.flags[FLG_STEP];
							st_next.vec = VEC_STEP;
						end
						EV_INTR: begin
							// Masked requests are not held pending, though vec still records their vector; the requester must hold its line
							take = st_reg.flags[FLG_INTEN];
							st_next.vec = vec_in;
						end
						EV_NMI: begin
							take = 1'b1;
							st_next.vec = VEC_NMI;
						end
						EV_EXC: begin
							take = 1'b1;
							st_next.vec = vec_in;
							st_next.fault = (vec_in == VEC_DIVIDE) || (vec_in == VEC_RANGE) ||
								(vec_in == VEC_BAD_OP) || (vec_in == VEC_EXT_NA);
						end
						EV_SOFT_INT: begin
							take = 1'b1;
							st_next.vec = vec_in;
						end
						EV_IRET: begin
							st_next.flags = (i_wb_dat[31:16] & FLAGS_WMASK) | FLAGS_RESET;
						end
						default: ;
					endcase
					st_next.taken = take;
					if (take) begin
						st_next.saved = st_reg.flags;
						st_next.flags[FLG_STEP] = 1'b0;
						st_next.flags[FLG_INTEN] = 1'b0;
					end
				end
				default: ;
			endcase
		end
	end

	always_ff @(posedge i_core_clk) begin
		if (i_reset) begin
			st_reg <= '0;
			st_reg.flags <= FLAGS_RESET;
			st_reg.seg <= {SEG_OTHER_RESET, SEG_OTHER_RESET, SEG_CODE_RESET, SEG_OTHER_RESET};
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_wb_ack = st_reg.ack;
	assign o_wb_dat = st_reg.dat;

	sequence s_wr(logic [7:0] off);
		i_wb_cyc && i_wb_stb && i_wb_we && !st_reg.ack && i_wb_adr == off;
	endsequence

	sequence s_event(logic [2:0] kind);
		s_wr(OFF_EVENT) ##0 i_wb_dat[EVT_KIND_LSB +: 3] == kind;
	endsequence

	property p_sign;
		@(posedge i_core_clk) disable iff (i_reset)
		st_reg.alu_done |-> st_reg.flags[FLG_SIGN] == (st_reg.alu_word ? st_reg.result[15] : st_reg.result[7]);
	endproperty
	a_sign: assert property (p_sign) else $error("sign flag does not match result top bit");

	property p_ovf;
		@(posedge i_core_clk) disable iff (i_reset)
		s_wr(OFF_ALU_CTRL) ##0 (i_wb_dat[3:0] == 4'h8) |=> st_reg.flags[FLG_OVF] ==
			(($past(st_reg.opa[15]) == $past(st_reg.opb[15])) && (st_reg.result[15] != $past(st_reg.opa[15])));
	endproperty
	a_ovf: assert property (p_ovf) else $error("overflow flag wrong after word add");

	property p_zero_parity;
		@(posedge i_core_clk) disable iff (i_reset)
		st_reg.alu_done |-> st_reg.flags[FLG_PARITY] == ~^st_reg.result[7:0] &&
			st_reg.flags[FLG_ZERO] == (st_reg.result == 16'h0000);
	endproperty
	a_zero_parity: assert property (p_zero_parity) else $error("zero or parity flag wrong");

	property p_step;
		@(posedge i_core_clk) disable iff (i_reset)
		s_event(3'b000) ##0 st_reg.flags[FLG_STEP] |=> st_reg.taken && st_reg.vec == VEC_STEP && !st_reg.flags[FLG_STEP];
	endproperty
	a_step: assert property (p_step) else $error("single step not taken or flag not cleared");

	property p_intr_mask;
		@(posedge i_core_clk) disable iff (i_reset)
		s_event(3'b001) ##0 !st_reg.flags[FLG_INTEN] |=> !st_reg.taken ##1 !st_reg.flags[FLG_INTEN];
	endproperty
	a_intr_mask: assert property (p_intr_mask) else $error("masked request was taken");

	property p_dir;
		@(posedge i_core_clk) disable iff (i_reset)
		s_wr(OFF_STR_STEP) ##0 (i_wb_dat[2:0] == 3'b101) && st_reg.flags[FLG_DIR]
			|=> st_reg.dst_idx == $past(st_reg.dst_idx) - 16'h0002;
	endproperty
	a_dir: assert property (p_dir) else $error("destination index not decremented by two");

	property p_disp;
		@(posedge i_core_clk) disable iff (i_reset)
		(st_reg.ea_ctrl[2:0] == 3'b000) && !st_reg.ea_ctrl[EA_DISPW_BIT]
			|=> st_reg.ea_off == {{8{$past(st_reg.disp[7])}}, $past(st_reg.disp[7:0])};
	endproperty
	a_disp: assert property (p_disp) else $error("short displacement not sign extended");

	property p_fetch;
		@(posedge i_core_clk) disable iff (i_reset)
		st_reg.ea_ctrl[EA_REF_LSB +: 2] == 2'b11 |=> st_reg.ea_seg == SEG_CODE && st_reg.ea_seg_val == $past(st_reg.seg[1]);
	endproperty
	a_fetch: assert property (p_fetch) else $error("fetch not using code segment");

	property p_io;
		@(posedge i_core_clk) disable iff (i_reset)
		st_reg.io_ctrl[IO_IMM_BIT] |=> st_reg.io_addr == {8'h00, $past(st_reg.io_ctrl[7:0])};
	endproperty
	a_io: assert property (p_io) else $error("immediate port not zero extended");

	property p_fault;
		@(posedge i_core_clk) disable iff (i_reset)
		s_event(3'b011) ##0 i_wb_dat[7:0] == VEC_OVF_TRAP |=> st_reg.taken && !st_reg.fault;
	endproperty
	a_fault: assert property (p_fault) else $error("overflow trap marked as faulting");

	property p_ack;
		@(posedge i_core_clk) disable iff (i_reset)
		i_wb_cyc && i_wb_stb && !st_reg.ack |=> st_reg.ack ##1 !st_reg.ack;
	endproperty
	a_ack: assert property (p_ack) else $error("bus answer not a single cycle");

	property p_logic_clear;
		@(posedge i_core_clk) disable iff (i_reset)
		s_wr(OFF_ALU_CTRL) ##0 i_wb_dat[2] && (i_wb_dat[1:0] != 2'b11)
			|=> !st_reg.flags[FLG_CARRY] && !st_reg.flags[FLG_OVF] && !st_reg.flags[FLG_AUX];
	endproperty
	a_logic_clear: assert property (p_logic_clear) else $error("logical op left carry, overflow or aux set");

	property p_word_carry;
		@(posedge i_core_clk) disable iff (i_reset)
		s_wr(OFF_ALU_CTRL) ##0 (i_wb_dat[3:0] == 4'h8)
			|=> st_reg.flags[FLG_CARRY] == ((17'($past(st_reg.opa)) + 17'($past(st_reg.opb))) > 17'h0FFFF);
	endproperty
	a_word_carry: assert property (p_word_carry) else $error("carry flag wrong after word add");

	property p_nmi;
		@(posedge i_core_clk) disable iff (i_reset)
		s_event(3'b010) |=> st_reg.taken && st_reg.vec == VEC_NMI && !st_reg.flags[FLG_INTEN];
	endproperty
	a_nmi: assert property (p_nmi) else $error("non-maskable event not taken on its fixed vector");

	property p_div_fault;
		@(posedge i_core_clk) disable iff (i_reset)
		s_event(3'b011) ##0 i_wb_dat[7:0] == VEC_DIVIDE |=> st_reg.taken && st_reg.fault && st_reg.vec == VEC_DIVIDE;
	endproperty
	a_div_fault: assert property (p_div_fault) else $error("divide error not marked as faulting");

	property p_src_inc;
		@(posedge i_core_clk) disable iff (i_reset)
		s_wr(OFF_STR_STEP) ##0 (i_wb_dat[1:0] == 2'b10) && !st_reg.flags[FLG_DIR]
			|=> st_reg.src_idx == $past(st_reg.src_idx) + 16'h0001;
	endproperty
	a_src_inc: assert property (p_src_inc) else $error("source index not incremented by one");
endmodule : fag_core

/* shared/fag_pkg.sv */
package fag_pkg;
	localparam logic [7:0] OFF_FLAGS = 8'h00;
	localparam logic [7:0] OFF_OPA = 8'h04;
	localparam logic [7:0] OFF_OPB = 8'h08;
	localparam logic [7:0] OFF_ALU_CTRL = 8'h0C;
	localparam logic [7:0] OFF_RESULT = 8'h10;
	localparam logic [7:0] OFF_SEG_BASE = 8'h14;
	localparam logic [7:0] OFF_BASE_B = 8'h24;
	localparam logic [7:0] OFF_BASE_SP = 8'h28;
	localparam logic [7:0] OFF_SRC_IDX = 8'h2C;
	localparam logic [7:0] OFF_DST_IDX = 8'h30;
	localparam logic [7:0] OFF_PORT_ADDR = 8'h34;
	localparam logic [7:0] OFF_EA_CTRL = 8'h38;
	localparam logic [7:0] OFF_DISP = 8'h3C;
	localparam logic [7:0] OFF_EA_PTR = 8'h40;
	localparam logic [7:0] OFF_IO_CTRL = 8'h44;
	localparam logic [7:0] OFF_IO_ADDR = 8'h48;
	localparam logic [7:0] OFF_EVENT = 8'h4C;
	localparam logic [7:0] OFF_EVT_STATUS = 8'h50;
	localparam logic [7:0] OFF_STR_STEP = 8'h54;
	localparam logic [7:0] OFF_BCD_STATUS = 8'h58;
	localparam int FLG_CARRY = 0;
	localparam int FLG_PARITY = 2;
	localparam int FLG_AUX = 4;
	localparam int FLG_ZERO = 6;
	localparam int FLG_SIGN = 7;
	localparam int FLG_STEP = 8;
	localparam int FLG_INTEN = 9;
	localparam int FLG_DIR = 10;
	localparam int FLG_OVF = 11;
	localparam logic [15:0] FLAGS_RESET = 16'h0002;
	localparam logic [15:0] FLAGS_WMASK = 16'h0FD5;
	localparam logic [15:0] SEG_CODE_RESET = 16'hF000;
	localparam logic [15:0] SEG_OTHER_RESET = 16'h0000;
	localparam int ALU_OP_LSB = 0;
	localparam int ALU_WORD_BIT = 3;
	localparam int EA_MODE_LSB = 0;
	localparam int EA_BASE_BIT = 3;
	localparam int EA_INDEX_BIT = 4;
	localparam int EA_IND_LSB = 5;
	localparam int EA_DISPW_BIT = 7;
	localparam int EA_OVR_EN_BIT = 8;
	localparam int EA_OVR_LSB = 9;
	localparam int EA_REF_LSB = 11;
	localparam int IO_PORT_LSB = 0;
	localparam int IO_IMM_BIT = 8;
	localparam logic [15:0] IO_RSV_LO = 16'h00F8;
	localparam logic [15:0] IO_RSV_HI = 16'h00FF;
	localparam int EVT_VEC_LSB = 0;
	localparam int EVT_KIND_LSB = 8;
	localparam int STR_WORD_BIT = 0;
	localparam int STR_SRC_BIT = 1;
	localparam int STR_DST_BIT = 2;
	localparam logic [7:0] VEC_DIVIDE = 8'h00;
	localparam logic [7:0] VEC_STEP = 8'h01;
	localparam logic [7:0] VEC_NMI = 8'h02;
	localparam logic [7:0] VEC_BREAK = 8'h03;
	localparam logic [7:0] VEC_OVF_TRAP = 8'h04;
	localparam logic [7:0] VEC_RANGE = 8'h05;
	localparam logic [7:0] VEC_BAD_OP = 8'h06;
	localparam logic [7:0] VEC_EXT_NA = 8'h07;
	localparam logic [7:0] VEC_EXT_ERR = 8'h10;
	localparam logic [7:0] VEC_USER_LO = 8'h20;
	typedef enum logic [2:0] {ALU_ADD = 3'b000, ALU_ADC = 3'b001, ALU_SUB = 3'b010, ALU_SBB = 3'b011,
		ALU_AND = 3'b100, ALU_OR = 3'b101, ALU_XOR = 3'b110, ALU_CMP = 3'b111} fag_alu_op_type;
	typedef enum logic [2:0] {MD_DIRECT = 3'b000, MD_REG_IND = 3'b001, MD_BASED = 3'b010,
		MD_INDEXED = 3'b011, MD_BASE_IDX = 3'b100, MD_BASE_IDX_DISP = 3'b101} fag_mode_type;
	typedef enum logic [1:0] {SEG_EXTRA = 2'b00, SEG_CODE = 2'b01, SEG_STACK = 2'b10,
		SEG_DATA = 2'b11} fag_seg_type;
	typedef enum logic [1:0] {REF_DATA = 2'b00, REF_STR_DST = 2'b01, REF_STACK = 2'b10,
		REF_FETCH = 2'b11} fag_ref_type;
	typedef enum logic [2:0] {EV_INSTR_DONE = 3'b000, EV_INTR = 3'b001, EV_NMI = 3'b010,
		EV_EXC = 3'b011, EV_SOFT_INT = 3'b100, EV_IRET = 3'b101} fag_evt_type;
endpackage : fag_pkg

/* hdl/fag_alu_flags.sv */
`timescale 1ns/1ps
module fag_alu_flags import fag_pkg::*; (
	input wire logic [2:0] i_op,
	input wire logic i_word,
	input wire logic [15:0] i_a,
	input wire logic [15:0] i_b,
	input wire logic i_carry,
	output logic [15:0] o_result,
	output logic o_carry,
	output logic o_parity,
	output logic o_aux,
	output logic o_zero,
	output logic o_sign,
	output logic o_ovf
);
	always_comb begin
		logic sub;
		logic cin;
		logic [15:0] bx;
		logic [16:0] s16;
		logic [8:0] s8;
		logic cout;
		logic a_msb;
		logic b_msb;
		logic r_msb;
		sub = (i_op == ALU_SUB) || (i_op == ALU_SBB) || (i_op == ALU_CMP);
		cin = ((i_op == ALU_ADC) || (i_op == ALU_SBB)) ? i_carry : 1'b0;
		// Subtraction is a + ~b + 1 - borrow, all two's complement
		bx = sub ? ~i_b : i_b;
		s16 = {1'b0, i_a} + {1'b0, bx} + {16'h0000, (sub ? ~cin : cin)};
		s8 = {1'b0, i_a[7:0]} + {1'b0, bx[7:0]} + {8'h00, (sub ? ~cin : cin)};
		case (fag_alu_op_type'(i_op))
			ALU_AND: o_result = i_a & i_b;
			ALU_OR: o_result = i_a | i_b;
			ALU_XOR: o_result = i_a ^ i_b;
			default: o_result = s16[15:0];
		endcase
		if (!i_word) begin
			o_result = {8'h00, o_result[7:0]};
		end
		cout = i_word ? s16[16] : s8[8];
		a_msb = i_word ? i_a[15] : i_a[7];
		b_msb = i_word ? bx[15] : bx[7];
		r_msb = i_word ? o_result[15] : o_result[7];
		if (i_op[2] && (i_op != ALU_CMP)) begin
			o_carry = 1'b0;
			o_ovf = 1'b0;
			o_aux = 1'b0;
		end else begin
			o_carry = sub ? ~cout : cout;
			o_ovf = (a_msb == b_msb) && (r_msb != a_msb);
			o_aux = i_a[4] ^ i_b[4] ^ o_result[4];
		end
		o_sign = r_msb;
		o_zero = i_word ? (o_result == 16'h0000) : (o_result[7:0] == 8'h00);
		o_parity = ~^o_result[7:0];
	end
endmodule : fag_alu_flags

/* hdl/fag_addr_gen.sv */
`timescale 1ns/1ps
module fag_addr_gen import fag_pkg::*; (
	input wire logic [15:0] i_ctrl,
	input wire logic [15:0] i_disp,
	input wire logic [15:0] i_base_b,
	input wire logic [15:0] i_base_sp,
	input wire logic [15:0] i_src_idx,
	input wire logic [15:0] i_dst_idx,
	input wire logic [3:0][15:0] i_seg,
	output logic [15:0] o_offset,
	output logic [1:0] o_seg_idx,
	output logic [15:0] o_seg_val
);
	always_comb begin
		logic [15:0] disp_ext;
		logic [15:0] base;
		logic [15:0] index;
		logic [15:0] ind;
		logic uses_sp;
		fag_mode_type mode;
		fag_ref_type kind;
		ind = 16'h0000;
		mode = fag_mode_type'(i_ctrl[EA_MODE_LSB +: 3]);
		kind = fag_ref_type'(i_ctrl[EA_REF_LSB +: 2]);
		disp_ext = i_ctrl[EA_DISPW_BIT] ? i_disp : {{8{i_disp[7]}}, i_disp[7:0]};
		base = i_ctrl[EA_BASE_BIT] ? i_base_sp : i_base_b;
		index = i_ctrl[EA_INDEX_BIT] ? i_dst_idx : i_src_idx;
		case (i_ctrl[EA_IND_LSB +: 2])
			2'b00: ind = i_src_idx;
			2'b01: ind = i_dst_idx;
			2'b10: ind = i_base_b;
			default: ind = i_base_sp;
		endcase
		uses_sp = 1'b0;
		// Sums wrap at 16 bits; the carry is simply not kept
		case (mode)
			MD_DIRECT: o_offset = disp_ext;
			MD_REG_IND: begin
				o_offset = ind;
				uses_sp = (i_ctrl[EA_IND_LSB +: 2] == 2'b11);
			end
			MD_BASED: begin
				o_offset = base + disp_ext;
				uses_sp = i_ctrl[EA_BASE_BIT];
			end
			MD_INDEXED: o_offset = index + disp_ext;
			MD_BASE_IDX: begin
				o_offset = base + index;
				uses_sp = i_ctrl[EA_BASE_BIT];
			end
			MD_BASE_IDX_DISP: begin
				o_offset = base + index + disp_ext;
				uses_sp = i_ctrl[EA_BASE_BIT];
			end
			default: o_offset = 16'h0000;
		endcase
		if (kind == REF_FETCH) begin
			o_seg_idx = SEG_CODE;
		end else if (i_ctrl[EA_OVR_EN_BIT]) begin
			o_seg_idx = i_ctrl[EA_OVR_LSB +: 2];
		end else if (kind == REF_STACK || uses_sp) begin
			o_seg_idx = SEG_STACK;
		end else if (kind == REF_STR_DST) begin
			o_seg_idx = SEG_EXTRA;
		end else begin
			o_seg_idx = SEG_DATA;
		end
		o_seg_val = i_seg[o_seg_idx];
	end
endmodule : fag_addr_gen

/* verif/fag_wb_master.sv */
`timescale 1ns/1ps
module fag_wb_master (
	input wire logic i_core_clk,
	input wire logic i_ack,
	input wire logic [31:0] i_dat,
	output logic o_cyc,
	output logic o_stb,
	output logic o_we,
	output logic [7:0] o_adr,
	output logic [3:0] o_sel,
	output logic [31:0] o_dat
);
	initial {o_cyc, o_stb, o_we, o_adr, o_sel, o_dat} = '0;
	// Request held until ack is sampled; the next call leaves one idle cycle before rising again
	task automatic xfer(input logic we, input logic [7:0] adr, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge i_core_clk);
		o_cyc <= 1'b1;
		o_stb <= 1'b1;
		o_we <= we;
		o_adr <= adr;
		o_sel <= 4'hF;
		o_dat <= wd;
		do @(posedge i_core_clk); while (i_ack !== 1'b1);
		rd = i_dat;
		o_cyc <= 1'b0;
		o_stb <= 1'b0;
	endtask : xfer
endmodule : fag_wb_master

/* verif/fag_core_tb.sv */
`timescale 1ns/1ps
`define CK(g, e) begin total_checks++; if ((g) !== (e)) begin failures++; $display("[FAIL] %0t got %h exp %h", $time, (g), (e)); end end
module fag_core_tb import fag_pkg::*;;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic cyc, stb, we, ack, usp, tk, rf;
	logic [7:0] adr, vec;
	logic [3:0] sel;
	logic [2:0] md;
	logic [1:0] sg;
	logic [31:0] wdat, rdat, rd, er;
	logic [15:0] v [9];
	logic [15:0] a, b, d, ctl, ds, off, pa, fl;
	logic [7:0] exc [6] = '{8'h00, 8'h04, 8'h05, 8'h06, 8'h07, 8'h10};
	int seed = 32'hA427;
	int i, j, k, failures, total_checks, cycles;
	fag_core dut (.i_core_clk(clk), .i_reset(rst), .i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr),
		.i_wb_sel(sel), .i_wb_dat(wdat), .o_wb_ack(ack), .o_wb_dat(rdat));
	fag_wb_master m (.i_core_clk(clk), .i_ack(ack), .i_dat(rdat), .o_cyc(cyc), .o_stb(stb), .o_we(we),
		.o_adr(adr), .o_sel(sel), .o_dat(wdat));
	task automatic wr(input logic [7:0] ad, input logic [31:0] dt);
		m.xfer(1'b1, ad, dt, rd);
	endtask : wr
	task automatic rc(input logic [7:0] ad, input logic [31:0] e);
		m.xfer(1'b0, ad, 32'h0, rd);
		`CK(rd, e)
	endtask : rc
	// Width-masked integer arithmetic; carry and borrow both show up as bit n of r
	function automatic logic [31:0] alu_ref(input int op, input int w, input int a, input int b, input int c);
		int n, m, r, x, f;
		n = w ? 16 : 8;
		m = (1 << n) - 1;
		a &= m;
		b &= m;
		if (op != 1 && op != 3) c = 0;
		x = op < 2 ? m : 0;
		case (op)
			0, 1: r = a + b + c;
			2, 3, 7: r = a - b - c;
			4: r = a & b;
			5: r = a | b;
			default: r = a ^ b;
		endcase
		f = 0;
		if (op < 4 || op == 7) f = (r >> n & 1) | ((a ^ b ^ r) & 16) | ((((a ^ r) & (a ^ b ^ x)) >> (n - 1) & 1) << 11);
		r &= m;
		f |= 2 | (!(^r[7:0]) << 2) | ((r == 0) << 6) | ((r >> (n - 1) & 1) << 7);
		return {f[15:0], r[15:0]};
	endfunction : alu_ref
	task final_report;
		if (failures == 0 && total_checks > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : final_report
	always #5 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			final_report();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		rc(OFF_FLAGS, 32'h00000002);
		rc(OFF_SEG_BASE + 8'h04, 32'h0000F000);
		rc(OFF_SEG_BASE + 8'h0C, 32'h0);
		wr(8'hFC, 32'hFFFFFFFF);
		rc(8'hFC, 32'h0);
		wr(OFF_RESULT, 32'h0000FFFF);
		rc(OFF_RESULT, 32'h0);
		// Index bits pick op, width and carry-in so every combination is hit
		for (i = 0; i < 64; i++) begin
			a = 16'($random(seed));
			b = 16'($random(seed));
			if (i % 4 == 0) a[7:0] = 8'(i * 3);
			wr(OFF_FLAGS, {31'h0, i[4]});
			wr(OFF_OPA, {16'h0, a});
			wr(OFF_OPB, {16'h0, b});
			rc(OFF_BCD_STATUS, {30'h0, a[7:4] < 10 && a[3:0] < 10, a[7:0] < 10});
			wr(OFF_ALU_CTRL, {28'h0, i[3], 3'(i)});
			er = alu_ref(i % 8, i[3], a, b, i[4]);
			rc(OFF_RESULT, {16'h0, er[15:0]});
			rc(OFF_FLAGS, {16'h0, er[31:16]});
		end
		for (i = 0; i < 48; i++) begin
			for (j = 0; j < 9; j++) begin
				v[j] = 16'($random(seed));
				wr(OFF_SEG_BASE + 8'(4 * j), {16'h0, v[j]});
			end
			ctl = 16'($random(seed)) & 16'h1FF8 | 16'(i % 6);
			d = 16'($random(seed));
			wr(OFF_EA_CTRL, {16'h0, ctl});
			wr(OFF_DISP, {16'h0, d});
			md = ctl[2:0];
			ds = ctl[EA_DISPW_BIT] ? d : {{8{d[7]}}, d[7:0]};
			off = (md == 1 || md == 4 ? 16'h0 : ds) + (md == 2 || md > 3 ? (ctl[EA_BASE_BIT] ? v[5] : v[4]) : 16'h0)
				+ (md > 2 && md != 3'd2 ? (ctl[EA_INDEX_BIT] ? v[7] : v[6]) : 16'h0);
			if (md == 1) off = ctl[6] ? v[4 + ctl[5]] : v[6 + ctl[5]];
			usp = md == 1 ? ctl[6:5] == 2'd3 : (md == 2 || md > 3) && ctl[EA_BASE_BIT];
			sg = ctl[12:11] == 3 ? 2'd1 : ctl[EA_OVR_EN_BIT] ? ctl[10:9] : (ctl[12:11] == 2 || usp) ? 2'd2
				: ctl[12:11] == 1 ? 2'd0 : 2'd3;
			rc(OFF_EA_PTR, {v[sg], off});
			ctl = (i % 8 == 0) ? 16'h01F8 + 16'(i / 8) : 16'($random(seed)) & 16'h01FF;
			wr(OFF_IO_CTRL, {16'h0, ctl});
			pa = ctl[IO_IMM_BIT] ? {8'h0, ctl[7:0]} : v[8];
			rc(OFF_IO_ADDR, {15'h0, pa >= IO_RSV_LO && pa <= IO_RSV_HI, pa});
			fl = 16'($random(seed)) & 16'h0400;
			ctl = 16'($random(seed)) & 16'h0007;
			wr(OFF_FLAGS, {16'h0, fl});
			wr(OFF_STR_STEP, {16'h0, ctl});
			ds = fl[FLG_DIR] ? -(16'h1 + ctl[0]) : 16'h1 + ctl[0];
			rc(OFF_SRC_IDX, {16'h0, v[6] + (ctl[STR_SRC_BIT] ? ds : 16'h0)});
			rc(OFF_DST_IDX, {16'h0, v[7] + (ctl[STR_DST_BIT] ? ds : 16'h0)});
		end
		// Step and NMI get a wrong vector field written, since theirs must come from inside
		for (k = 0; k < 30; k++) begin
			fl = 16'($random(seed)) & FLAGS_WMASK | 16'h0002;
			vec = k % 5 == 0 ? VEC_STEP : k % 5 == 1 ? VEC_USER_LO + 8'(k) : k % 5 == 2 ? VEC_NMI
				: k % 5 == 3 ? exc[k / 5] : VEC_BREAK;
			tk = (k % 5 == 0) ? fl[FLG_STEP] : (k % 5 == 1) ? fl[FLG_INTEN] : 1'b1;
			rf = (k % 5 == 3) && (vec == 0 || (vec > 4 && vec < 8));
			wr(OFF_FLAGS, {16'h0, fl});
			wr(OFF_EVENT, {21'h0, 3'(k % 5), vec ^ (k % 5 % 2 == 0 && k % 5 < 4 ? 8'h5A : 8'h00)});
			m.xfer(1'b0, OFF_EVT_STATUS, 32'h0, rd);
			`CK(rd[8], tk)
			if (tk) `CK(rd, {fl, 6'h0, rf, 1'b1, vec})
			rc(OFF_FLAGS, {16'h0, tk ? fl & 16'hFCFF : fl});
			wr(OFF_EVENT, {fl ^ 16'h0F00, 5'h00, 3'h5, 8'h00});
			rc(OFF_FLAGS, {16'h0, fl ^ 16'h0F00});
		end
		final_report();
	end
endmodule : fag_core_tb
